//--- verilog/sld_pkg.sv
package sld_pkg;

	localparam int SLD_CHANNELS = 12;
	localparam int SLD_BUF_DEPTH = 2;

	localparam logic [SLD_CHANNELS-1:0] SLD_WORD_CLEAR = 12'h000;
	localparam logic [SLD_CHANNELS-1:0] SLD_DRAIN_LEVEL = 12'h000;
	localparam logic SLD_LOW = 1'h0;
	localparam logic SLD_HIGH = 1'h1;

	// Clock rate of the sampling domain, for reference in counts
	localparam int SLD_CLK_MHZ = 200;

	typedef struct packed {
		logic [SLD_CHANNELS-1:0] bits;
	} sld_word_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} sld_edge_t;

	typedef enum logic [1:0] {
		SLD_RUN = 2'b00,
		SLD_CLEARED = 2'b01,
		SLD_HOT = 2'b10
	} sld_mode_t;

endpackage

//--- verilog/sld_buf.sv
`timescale 1ns/1ps
module sld_buf
	import sld_pkg::*;
#(
	parameter int DEPTH = SLD_BUF_DEPTH
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input sld_word_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output sld_word_t out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	sld_word_t mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
		next_ptr = (p == LAST) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (cnt_q != FULL);
	assign out_valid = (cnt_q != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q];

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= next_ptr(wr_q);
			end
			if (pop) begin
				rd_q <= next_ptr(rd_q);
			end
			case ({push, pop})
				2'b10: cnt_q <= cnt_q + 1'b1;
				2'b01: cnt_q <= cnt_q - 1'b1;
				default: cnt_q <= cnt_q;
			endcase
		end
	end
endmodule

//--- verilog/sld_top.sv
// Contract
// - Twelve-stage shift feeds twelve-bit storage
// - Shift on shift rise, capture on latch
// - Storage reaches outputs only while clear high
// - Clear low zeroes the shift and storage registers
// - Serial output updates on shift falling edge
// - Serial tap latency set by tap parameter
// - With the gate open, drains change only after latch rising edge
// - Enable high forces all drains off
// - Enable low passes storage straight through
// - Low buffer bit leaves drain open
// - High buffer bit makes drain sink
// - Over-temperature forces all drains open
// - Normal drive resumes when over-temperature ends
`timescale 1ns/1ps
module sld_top
	import sld_pkg::*;
#(
	parameter int CHANNELS = SLD_CHANNELS,
	parameter int OUT_TAP = SLD_CHANNELS - 1
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic shift_clk,
	input wire logic latch_clk,
	input wire logic serial_in,
	input wire logic clear_n,
	input wire logic out_en_n,
	input wire logic over_temp,
	output logic serial_out,
	output logic [SLD_CHANNELS-1:0] drain_o,
	output logic [SLD_CHANNELS-1:0] drain_oe,
	output logic latch_ready,
	output sld_mode_t mode
);
	logic shift_clk_q;
	logic latch_clk_q;
	sld_edge_t shift_edge;
	sld_edge_t latch_edge;
	logic latch_rise;
	sld_word_t shift_q;
	sld_word_t shift_d;
	sld_word_t store_q;
	logic serial_out_q;
	logic [SLD_CHANNELS-1:0] drain_oe_q;
	logic gate_open;
	logic [SLD_CHANNELS-1:0] drain_o_q;
	logic latch_ready_q;
	sld_mode_t mode_q;
	sld_mode_t mode_d;
	logic buf_in_ready;
	logic buf_out_valid;
	sld_word_t buf_out_data;
	logic store_take;

	function automatic sld_edge_t edges(input logic now, input logic was);
		sld_edge_t e;
		e.rise = now && !was;
		e.fall = !now && was;
		return e;
	endfunction

	// Pins are synchronous to clk_sys, so one delay stage finds the edges
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift_clk_q <= SLD_LOW;
			latch_clk_q <= SLD_LOW;
		end else begin
			shift_clk_q <= shift_clk;
			latch_clk_q <= latch_clk;
		end
	end

	assign shift_edge = edges(shift_clk, shift_clk_q);
	assign latch_edge = edges(latch_clk, latch_clk_q);
	assign latch_rise = latch_edge.rise;

	always_comb begin
		shift_d = shift_q;
		if (shift_edge.rise) begin
			shift_d.bits = {shift_q.bits[SLD_CHANNELS-2:0], serial_in};
		end
	end

	// Over-temperature never touches the register contents
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift_q <= SLD_WORD_CLEAR;
		end else if (!clear_n) begin
			shift_q <= SLD_WORD_CLEAR;
		end else begin
			shift_q <= shift_d;
		end
	end

	// Snapshot taken at the latch edge sits here for one cycle; clear low flushes it
	sld_buf #(
		.DEPTH(SLD_BUF_DEPTH)
	) u_buf (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.flush(!clear_n),
		.in_valid(latch_rise && clear_n),
		.in_ready(buf_in_ready),
		.in_data(shift_q),
		.out_valid(buf_out_valid),
		.out_ready(clear_n),
		.out_data(buf_out_data)
	);

	assign store_take = buf_out_valid && clear_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			store_q <= SLD_WORD_CLEAR;
		end else if (!clear_n) begin
			store_q <= SLD_WORD_CLEAR;
		end else if (store_take) begin
			store_q <= buf_out_data;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			latch_ready_q <= SLD_LOW;
		end else begin
			latch_ready_q <= buf_in_ready && clear_n;
		end
	end

	// Falling-edge retime gives the next device a half period of hold
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			serial_out_q <= SLD_LOW;
		end else if (!clear_n) begin
			serial_out_q <= SLD_LOW;
		end else if (shift_edge.fall) begin
			serial_out_q <= shift_q.bits[OUT_TAP];
		end
	end

	always_comb begin
		mode_d = SLD_RUN;
		if (!clear_n) begin
			mode_d = SLD_CLEARED;
		end else if (over_temp) begin
			mode_d = SLD_HOT;
		end
	end

	// Heat is a plain level here; its hysteresis lives off the block
	assign gate_open = clear_n && !over_temp
		&& !out_en_n;

	// One flop per drain, so every channel sees the gate together
	for (genvar c = 0; c < CHANNELS; c++) begin : g_drain
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				drain_oe_q[c] <= SLD_LOW;
			end else begin
				drain_oe_q[c] <= store_q.bits[c]
					&& gate_open;
			end
		end
	end

	// Drains only ever pull low; the enable carries the whole state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			drain_o_q <= SLD_DRAIN_LEVEL;
			mode_q <= SLD_CLEARED;
		end else begin
			drain_o_q <= SLD_DRAIN_LEVEL;
			mode_q <= mode_d;
		end
	end

	assign serial_out = serial_out_q;
	assign drain_oe = drain_oe_q;
	assign drain_o = drain_o_q;
	assign latch_ready = latch_ready_q;
	assign mode = mode_q;
endmodule

//--- tb/sld_ctl.sv
`timescale 1ns/1ps
module sld_ctl (
	input logic clk_sys,
	output logic shift_clk,
	output logic latch_clk,
	output logic serial_in
);
	initial {shift_clk, latch_clk, serial_in} = '0;
	task automatic pulse_latch;
		#10 latch_clk = 1;
		#10 latch_clk = 0;
	endtask
	// Shift clock rests low between frames; data moves after the fall
	task automatic send(input logic [11:0] v);
		for (int i = 11; i >= 0; i--) begin
			@(negedge clk_sys) serial_in = v[i];
			#10 shift_clk = 1;
			#10 shift_clk = 0;
		end
		pulse_latch();
		serial_in = ~serial_in;
	endtask
endmodule

//--- tb/sld_checker.sv
`timescale 1ns/1ps
module sld_checker
	import sld_pkg::*;
(
	input logic clk_sys,
	input logic resetn,
	input logic shift_clk,
	input logic latch_clk,
	input logic serial_in,
	input logic clear_n,
	input logic out_en_n,
	input logic over_temp,
	input logic serial_out,
	input logic [11:0] drain_o,
	input logic [11:0] drain_oe,
	input logic latch_ready,
	input sld_mode_t mode
);
	logic [4:0] l_q, s_q;
	wire ok = !out_en_n && clear_n && !over_temp;
	always_ff @(posedge clk_sys) l_q <= {l_q[3:0], latch_clk};
	always_ff @(posedge clk_sys) s_q <= {s_q[3:0], shift_clk};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_en_off: assert property (out_en_n |=> !drain_oe)
		else $error("en gate");
	a_hot_off: assert property (over_temp |=> !drain_oe)
		else $error("hot gate");
	a_clear_off: assert property (!clear_n |=> !drain_oe)
		else $error("clear gate");
	a_drain_low: assert property (drain_o == 12'h000)
		else $error("drain level");
	a_latch_cause: assert property ($past(ok, 2) && $past(ok)
		&& $changed(drain_oe) |-> |(l_q[3:0] & ~l_q[4:1]))
		else $error("no latch");
	a_serial_fall: assert property ($past(clear_n)
		&& $changed(serial_out) |-> |(~s_q[3:0] & s_q[4:1]))
		else $error("no fall");
	a_hot_mode: assert property (clear_n && over_temp
		|=> mode == SLD_HOT) else $error("hot mode");
	a_clear_mode: assert property (!clear_n |=> mode == SLD_CLEARED)
		else $error("clear mode");
	a_run_mode: assert property (clear_n && !over_temp
		|=> mode == SLD_RUN) else $error("run mode");
	a_ready_follow: assert property (latch_ready == $past(clear_n))
		else $error("ready level");
	cover property ($rose(latch_clk) ##3 drain_oe != 12'h000);
	cover property ($fell(over_temp));
	cover property ($rose(serial_out));
endmodule
bind sld_top sld_checker chk_u (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.shift_clk(shift_clk),
	.latch_clk(latch_clk),
	.serial_in(serial_in),
	.clear_n(clear_n),
	.out_en_n(out_en_n),
	.over_temp(over_temp),
	.serial_out(serial_out),
	.drain_o(drain_o),
	.drain_oe(drain_oe),
	.latch_ready(latch_ready),
	.mode(mode)
);

//--- tb/sld_top_test.sv
`timescale 1ns/1ps
module sld_top_test
	import sld_pkg::*;
;
	logic clk_sys = 0, resetn = 0, clear_n = 0, out_en_n = 1, over_temp = 0;
	logic shift_clk, latch_clk, serial_in, serial_out, latch_ready;
	logic [11:0] w, drain_o, drain_oe;
	logic [12:0] exp_q[$];
	logic [31:0] rs = 32'h0253f880;
	sld_mode_t mode;
	int err_total, tests_run, cyc;
	event look;
	always #2.5 clk_sys = ~clk_sys;
	sld_top dut_u (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.shift_clk(shift_clk),
		.latch_clk(latch_clk),
		.serial_in(serial_in),
		.clear_n(clear_n),
		.out_en_n(out_en_n),
		.over_temp(over_temp),
		.serial_out(serial_out),
		.drain_o(drain_o),
		.drain_oe(drain_oe),
		.latch_ready(latch_ready),
		.mode(mode)
	);
	sld_ctl ctl_u (
		.clk_sys(clk_sys),
		.shift_clk(shift_clk),
		.latch_clk(latch_clk),
		.serial_in(serial_in)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], ^(s & 32'h80200003)};
	endfunction
	task automatic note(input logic [12:0] e);
		repeat (6) @(negedge clk_sys);
		exp_q.push_back(e);
		->look;
	endtask
	task automatic chk(input logic [12:0] e, s);
		tests_run++;
		if (s !== e) err_total++;
		if (s !== e) $display("BAD outputs exp %h got %h", e, s);
	endtask
	always @(look)
		chk(exp_q.pop_front(), {serial_out, drain_oe});
	task automatic report_and_stop;
		$display("checks %0d bad %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys) if (++cyc == 5000) begin
		err_total++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		resetn = 1;
		@(negedge clk_sys) clear_n = 1;
		out_en_n = 0;
		for (int i = 0; i < 6; i++) begin
			rs = lfsr(rs);
			w = i ? rs[11:0] : 12'hfff;
			ctl_u.send(w);
			note({w[11], w});
		end
		// Words still load while either off path holds the drains
		for (int k = 1; k < 3; k++) begin
			{over_temp, out_en_n} = k[1:0];
			rs = lfsr(rs);
			w = rs[11:0];
			ctl_u.send(w);
			note({w[11], 12'h000});
			{over_temp, out_en_n} = 2'b00;
			note({w[11], w});
		end
		clear_n = 0;
		ctl_u.send(12'hfff);
		clear_n = 1;
		note(13'h0000);
		// A bare latch proves the shift stages were cleared too
		ctl_u.pulse_latch();
		note(13'h0000);
		report_and_stop;
	end
endmodule
